// [host_master_model.sv]
// Host-side model that issues register writes to the bank
`default_nettype none
module host_master_model
(
    // Clock
    input  wire logic                       clk,
    // Request from the bench
    input  wire logic                       go,
    input  wire logic [6:0]                 addr,
    input  wire logic [7:0]                 data,
    // Write strobe to the bank
    output var  wdog_bus_regs_pkg::reg_wr_t wr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] d;
    always_comb
    begin
        d = data;
        if (addr == wdog_bus_regs_pkg::WDOG_CTRL_ADDR)
            d[7] = ^data[6:0];
    end
    // Mode is written before any stop entry the bench commands
    always_ff @(posedge clk)
        wr_o <= '{wr: go, addr: addr, data: d};
endmodule
`default_nettype wire

// [wdog_bus_regs.sv]
// Watchdog control and bus transceiver control register bank
//
// Contract
// - Bit 6 turns watchdog off in stop
// - Bit 5 selects time-out or window watchdog
// - Bit 4 starts watchdog after bus wake
// - Bits 2:0 select the watchdog period
// - Reset 0x14; restart gives x0xx0100
// - Reserved bits always read zero
// - Hardware changes selective wake bit only on restart or soft reset
// - Sleep entry turns normal into wake-capable unless system error flag is set
// - Receive-only wakes on sleep, stays on stop
// - Off and wake-capable unchanged by sleep/stop
// - Fail-safe forces bus control to 0000_0x01
// - Development mode resets transceiver mode 011
// - Bus control resets zero, restart loads the restart mode
// - Second stop-off bit clears stop to normal
`default_nettype none
module wdog_bus_regs
(
    // Clock and reset
    input  wire logic                         SYS_CLK,
    input  wire logic                         RST_N,
    // Register access from the serial frame logic
    input  wire wdog_bus_regs_pkg::reg_wr_t   REG_WR,
    input  wire logic [6:0]                   REG_RD_ADDR,
    output var  logic [7:0]                   REG_RD_DATA,
    // Device state events
    input  wire wdog_bus_regs_pkg::hw_evt_t   HW_EVT,
    input  wire logic                         DEV_MODE,
    input  wire logic                         STOP_OFF_B_SET,
    // Decoded controls
    output var  logic                         STOP_WDOG_OFF_A,
    output var  logic                         STOP_WDOG_OFF_B,
    output var  logic                         WDOG_WINDOW_SELECT,
    output var  logic                         WDOG_START_ON_BUS_WAKE,
    output var  logic [2:0]                   WDOG_PERIOD_CODE,
    output var  logic [1:0]                   XCVR_MODE,
    output var  logic                         SELECTIVE_WAKE,
    output var  logic                         WDOG_PARITY_OK
);

    logic [7:0] wdog_r;
    logic [7:0] wdog_nxt;
    logic [2:0] bus_r;
    logic [2:0] bus_nxt;
    logic       off_b_r;
    logic       off_b_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic [2:0] bus_rst;
    logic       sel_wake_r;
    logic       sel_wake_nxt;
    logic       par_ok_r;
    logic       par_ok_nxt;

    wire logic wr_wdog = REG_WR.wr
                         && REG_WR.addr == wdog_bus_regs_pkg::WDOG_CTRL_ADDR;
    wire logic wr_bus  = REG_WR.wr
                         && REG_WR.addr == wdog_bus_regs_pkg::BUS_CTRL_ADDR;

    always_comb
    begin
        wdog_nxt  = wdog_r;
        bus_nxt   = bus_r;
        off_b_nxt = off_b_r;
        // Development mode picks normal mode for pin and soft reset alike
        bus_rst   = DEV_MODE ? wdog_bus_regs_pkg::XCVR_DEV_RESET
                             : wdog_bus_regs_pkg::BUS_CTRL_RESET[2:0];
        // Host writes touch only writable bits; the stored checksum
        // bit is kept as written, the parity check is reported
        if (wr_wdog)
        begin
            wdog_nxt = REG_WR.data & wdog_bus_regs_pkg::WDOG_RW_MASK;
        end
        if (wr_bus)
        begin
            bus_nxt = REG_WR.data[2:0];
        end
        if (STOP_OFF_B_SET)
        begin
            off_b_nxt = 1'b1;
        end
        // Mode entry rewrites; bit 2 is never touched here
        if (HW_EVT.sleep_entry)
        begin
            if ((bus_nxt[1:0] == wdog_bus_regs_pkg::XCVR_NORM
                 && !HW_EVT.system_error_flag)
                || bus_nxt[1:0] == wdog_bus_regs_pkg::XCVR_RXO)
            begin
                bus_nxt[1:0] = wdog_bus_regs_pkg::XCVR_WAKE;
            end
        end
        if (HW_EVT.stop_to_normal)
        begin
            off_b_nxt = 1'b0;
        end
        if (HW_EVT.failsafe_entry)
        begin
            bus_nxt[1:0] = wdog_bus_regs_pkg::XCVR_WAKE;
        end
        if (HW_EVT.restart)
        begin
            wdog_nxt[3:0] = wdog_bus_regs_pkg::WDOG_LOW_RESTART;
            wdog_nxt[wdog_bus_regs_pkg::WD_STOP_OFF_BIT] = 1'b0;
            bus_nxt = HW_EVT.restart_mode;
            off_b_nxt = 1'b0;
        end
        if (HW_EVT.soft_reset)
        begin
            wdog_nxt  = wdog_bus_regs_pkg::WDOG_CTRL_RESET;
            bus_nxt   = bus_rst;
            off_b_nxt = 1'b0;
        end
        unique case (REG_RD_ADDR)
            wdog_bus_regs_pkg::WDOG_CTRL_ADDR: rd_nxt = wdog_nxt;
            wdog_bus_regs_pkg::BUS_CTRL_ADDR:  rd_nxt = {5'h00, bus_nxt};
            default:                           rd_nxt = 8'h00;
        endcase
        // Decoded flags are registered so the outputs come from flops
        sel_wake_nxt = bus_nxt[wdog_bus_regs_pkg::SEL_WAKE_BIT]
                       && bus_nxt[1:0] != wdog_bus_regs_pkg::XCVR_OFF;
        par_ok_nxt   = ~^wdog_nxt;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            wdog_r  <= wdog_bus_regs_pkg::WDOG_CTRL_RESET;
            bus_r   <= bus_rst;
            off_b_r <= 1'b0;
            rd_r    <= 8'h00;
            sel_wake_r <= 1'b0;
            par_ok_r   <= ~^wdog_bus_regs_pkg::WDOG_CTRL_RESET;
        end
        else
        begin
            wdog_r  <= wdog_nxt;
            bus_r   <= bus_nxt;
            off_b_r <= off_b_nxt;
            rd_r    <= rd_nxt;
            sel_wake_r <= sel_wake_nxt;
            par_ok_r   <= par_ok_nxt;
        end
    end

    always_comb
    begin
        REG_RD_DATA            = rd_r;
        STOP_WDOG_OFF_A        = wdog_r[wdog_bus_regs_pkg::WD_STOP_OFF_BIT];
        STOP_WDOG_OFF_B        = off_b_r;
        WDOG_WINDOW_SELECT     = wdog_r[wdog_bus_regs_pkg::WD_WINDOW_BIT];
        WDOG_START_ON_BUS_WAKE = wdog_r[wdog_bus_regs_pkg::WD_BUSWAKE_BIT];
        WDOG_PERIOD_CODE       = wdog_r[2:0];
        XCVR_MODE              = bus_r[1:0];
        SELECTIVE_WAKE         = sel_wake_r;
        WDOG_PARITY_OK         = par_ok_r;
    end

    a_wdog_reset_val: assert property (@(posedge SYS_CLK)
        !RST_N |=> wdog_r == wdog_bus_regs_pkg::WDOG_CTRL_RESET)
        else $error("watchdog control not 0x14 after reset");

    a_rsvd_bit_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !wdog_r[wdog_bus_regs_pkg::WD_RSVD_BIT])
        else $error("reserved watchdog bit set");

    a_selwake_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !wr_bus && !HW_EVT.restart && !HW_EVT.soft_reset
        |=> $stable(bus_r[2]))
        else $error("selective wake bit changed by hardware");

    a_sleep_norm_wake: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.sleep_entry && !HW_EVT.system_error_flag && !wr_bus
        && !HW_EVT.restart && !HW_EVT.soft_reset
        && bus_r[1:0] == wdog_bus_regs_pkg::XCVR_NORM
        |=> bus_r[1:0] == wdog_bus_regs_pkg::XCVR_WAKE)
        else $error("normal mode not turned wake-capable on sleep");

    a_stop_rxo_stays: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.stop_entry && !HW_EVT.sleep_entry && !HW_EVT.failsafe_entry
        && !wr_bus && !HW_EVT.restart && !HW_EVT.soft_reset
        |=> $stable(bus_r))
        else $error("stop entry changed transceiver mode");

    a_failsafe_force: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.failsafe_entry && !HW_EVT.restart && !HW_EVT.soft_reset
        |=> bus_r[1:0] == wdog_bus_regs_pkg::XCVR_WAKE)
        else $error("fail-safe did not force wake-capable");

    a_dev_reset_mode: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.soft_reset && DEV_MODE
        |=> bus_r == wdog_bus_regs_pkg::XCVR_DEV_RESET)
        else $error("development reset mode not 011");

    a_offb_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.stop_to_normal |=> !off_b_r)
        else $error("second stop-off bit not cleared");

    a_restart_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.restart && !HW_EVT.soft_reset
        |=> wdog_r[3:0] == wdog_bus_regs_pkg::WDOG_LOW_RESTART
            && !wdog_r[wdog_bus_regs_pkg::WD_STOP_OFF_BIT])
        else $error("restart value of watchdog control wrong");

    a_read_bus: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        REG_RD_ADDR == wdog_bus_regs_pkg::BUS_CTRL_ADDR
        |=> REG_RD_DATA == {5'h00, bus_r})
        else $error("bus control read mismatch");

    a_dev_pin_reset: assert property (@(posedge SYS_CLK)
        !RST_N && DEV_MODE
        |=> bus_r == wdog_bus_regs_pkg::XCVR_DEV_RESET)
        else $error("development pin reset mode not 011");

    a_sleep_err_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        HW_EVT.sleep_entry && HW_EVT.system_error_flag && !wr_bus
        && !HW_EVT.failsafe_entry && !HW_EVT.restart && !HW_EVT.soft_reset
        && bus_r[1:0] == wdog_bus_regs_pkg::XCVR_NORM
        |=> bus_r[1:0] == wdog_bus_regs_pkg::XCVR_NORM)
        else $error("normal mode changed on sleep with system error");

endmodule
`default_nettype wire

// [wdog_bus_regs_bench.sv]
// Self-checking bench for the watchdog and bus control registers
`default_nettype none
module wdog_bus_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] WA = wdog_bus_regs_pkg::WDOG_CTRL_ADDR;
    localparam logic [6:0] BA = wdog_bus_regs_pkg::BUS_CTRL_ADDR;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic go = 1'b0;
    logic [6:0] wa = '0;
    logic [7:0] wd = '0;
    logic [6:0] ra = '0;
    logic dev = 1'b0;
    logic ob_set = 1'b0;
    logic [7:0] rdat;
    logic [2:0] per;
    logic [1:0] mode;
    logic oa, ob, win, bw, sw, pok;
    int n_fail = 0;
    int tests_run = 0;
    wdog_bus_regs_pkg::reg_wr_t wr;
    wdog_bus_regs_pkg::hw_evt_t evt = '0;
    host_master_model host (.clk(SYS_CLK), .go(go), .addr(wa), .data(wd),
        .wr_o(wr));
    wdog_bus_regs dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(wr),
        .REG_RD_ADDR(ra), .REG_RD_DATA(rdat), .HW_EVT(evt),
        .DEV_MODE(dev), .STOP_OFF_B_SET(ob_set), .STOP_WDOG_OFF_A(oa),
        .STOP_WDOG_OFF_B(ob), .WDOG_WINDOW_SELECT(win),
        .WDOG_START_ON_BUS_WAKE(bw), .WDOG_PERIOD_CODE(per),
        .XCVR_MODE(mode), .SELECTIVE_WAKE(sw), .WDOG_PARITY_OK(pok));
    initial forever #2.5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        go <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge SYS_CLK);
        go <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        ra <= a;
        @(posedge SYS_CLK);
        #1;
        chk(rdat, exp);
    endtask
    task automatic pulse(input int k);
        wdog_bus_regs_pkg::hw_evt_t p;
        p = '0;
        p.restart_mode = 3'h5;
        case (k)
            0: p.sleep_entry = 1'b1;
            1: p.stop_entry = 1'b1;
            2: p.failsafe_entry = 1'b1;
            3: p.stop_to_normal = 1'b1;
            4: p.restart = 1'b1;
            5: p.soft_reset = 1'b1;
            7:
            begin
                p.sleep_entry = 1'b1;
                p.system_error_flag = 1'b1;
            end
            default: ;
        endcase
        @(posedge SYS_CLK);
        evt <= p;
        ob_set <= (k == 6);
        @(posedge SYS_CLK);
        evt <= '0;
        ob_set <= 1'b0;
        #1;
    endtask
    task automatic t_wdog();
        logic [7:0] d;
        rd_chk(WA, 8'h14);
        rd_chk(BA, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            d = 8'h20 | 8'(c);
            wr_reg(WA, d);
            rd_chk(WA, {^d[6:0], d[6:0]});
            chk({5'h0, per}, 8'(c));
            chk({6'h0, win, pok}, 8'h03);
        end
        wr_reg(WA, 8'h58);
        rd_chk(WA, 8'hD0);
        chk({4'h0, oa, bw, win, pok}, 8'h0C);
        $display("t_wdog done");
    endtask
    task automatic t_bus();
        logic [7:0] st [7] = '{8'h07, 8'h06, 8'h02, 8'h01, 8'h00, 8'h05, 8'h03};
        logic [7:0] ex [7] = '{8'h05, 8'h05, 8'h02, 8'h01, 8'h00, 8'h05, 8'h03};
        int kd [7] = '{0, 0, 1, 0, 1, 1, 1};
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(BA, 8'hF8 | 8'(m));
            rd_chk(BA, 8'(m));
            chk({sw, 5'h0, mode}, {m[2] && m[1:0] != 0, 5'h0, m[1:0]});
        end
        for (int i = 0; i < 7; i++)
        begin
            wr_reg(BA, st[i]);
            pulse(kd[i]);
            rd_chk(BA, ex[i]);
        end
        wr_reg(BA, 8'h06);
        pulse(2);
        rd_chk(BA, 8'h05);
        wr_reg(BA, 8'h03);
        pulse(7);
        rd_chk(BA, 8'h03);
        $display("t_bus done");
    endtask
    task automatic t_restart();
        for (int k = 3; k < 5; k++)
        begin
            pulse(6);
            chk({7'h0, ob}, 8'h01);
            pulse(k);
            chk({7'h0, ob}, 8'h00);
        end
        wr_reg(WA, 8'h75);
        pulse(4);
        rd_chk(WA, 8'hB4);
        rd_chk(BA, 8'h05);
        @(posedge SYS_CLK);
        dev <= 1'b1;
        pulse(5);
        @(posedge SYS_CLK);
        dev <= 1'b0;
        rd_chk(BA, 8'h03);
        rd_chk(WA, 8'h14);
        $display("t_restart done");
    endtask
    task automatic t_pin_reset();
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        dev <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        dev <= 1'b0;
        rd_chk(BA, 8'h03);
        chk({6'h0, mode}, 8'h03);
        rd_chk(WA, 8'h14);
        $display("t_pin_reset done");
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #50000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        t_wdog();
        t_bus();
        t_restart();
        t_pin_reset();
        wrap_up();
    end
endmodule
`default_nettype wire

// [wdog_bus_regs_pkg.sv]
// Package: register map, field layout, reset values and events of the bank
`default_nettype none
package wdog_bus_regs_pkg;

    localparam logic [6:0] WDOG_CTRL_ADDR  = 7'h03;
    localparam logic [6:0] BUS_CTRL_ADDR   = 7'h04;

    localparam logic [7:0] WDOG_CTRL_RESET = 8'h14;
    localparam logic [7:0] BUS_CTRL_RESET  = 8'h00;
    localparam logic [3:0] WDOG_LOW_RESTART = 4'h4;

    localparam int WD_CHECKSUM_BIT = 7;
    localparam int WD_STOP_OFF_BIT = 6;
    localparam int WD_WINDOW_BIT   = 5;
    localparam int WD_BUSWAKE_BIT  = 4;
    localparam int WD_RSVD_BIT     = 3;
    localparam int SEL_WAKE_BIT    = 2;

    localparam logic [7:0] WDOG_RW_MASK = 8'hF7;
    localparam logic [7:0] BUS_RW_MASK  = 8'h07;

    // Transceiver mode codes in bits 1:0
    localparam logic [1:0] XCVR_OFF   = 2'h0;
    localparam logic [1:0] XCVR_WAKE  = 2'h1;
    localparam logic [1:0] XCVR_RXO   = 2'h2;
    localparam logic [1:0] XCVR_NORM  = 2'h3;
    localparam logic [2:0] XCVR_DEV_RESET = 3'h3;

    // Period times in ms, per code
    localparam int PERIOD_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic       soft_reset;
        logic       restart;
        logic [2:0] restart_mode;
        logic       sleep_entry;
        logic       stop_entry;
        logic       stop_to_normal;
        logic       failsafe_entry;
        logic       system_error_flag;
    } hw_evt_t;

endpackage
`default_nettype wire
